/* File: logic/mode_ctl_cfg.svh */
// Offsets, field positions and reset values of the mode control block.
// Operation
// - Reset clears the whole extended feature register.
// - Paging on with enable sets active.
// - Paging off while active clears active.
// - Checks on writes touching enable bits.
// - Enable change with paging on faults.
// - Paging on, enable set, extension off faults.
// - Clearing extension while active faults.
// - Activation with long code segment faults.
// - Activation with 16-bit task segment faults.
// - Long one, size zero: 64-bit mode.
// - Prefixes change operand and address sizes.
// - Long zero: compatibility, size bit picks width.
// - Long and size both one reserved.
// - Compatibility keeps extended translation and traps.
// - Legacy base writes touch low half only.
// - Extra registers kept; lost via legacy mode.
// - Protection enable write enters privilege zero.
// - Descriptor table registers untouched on activation.
// - Paging enable clear after reset.
// - Paging needs protection enable, now or before.
// - Protection enable is bit zero.
`ifndef MODE_CTL_CFG_SVH
`define MODE_CTL_CFG_SVH

// ==========================================================================
// Register byte addresses
`define ADDR_PRIMARY 12'h000
`define ADDR_FEATURE 12'h004
`define ADDR_EXT 12'h008
`define ADDR_BASE_LO 12'h00c
`define ADDR_BASE_HI 12'h010
`define ADDR_SEG 12'h014
`define ADDR_STATUS 12'h018
`define ADDR_PREFIX 12'h01c

// ==========================================================================
// Field positions
`define BIT_PE 0
`define BIT_PG 31
`define BIT_PAE 5
`define BIT_LME 8
`define BIT_LMA 10
`define BIT_SEG_L 0
`define BIT_SEG_D 1
`define BIT_TASK16 2
`define BIT_PFX_OP64 0
`define BIT_PFX_OP16 1
`define BIT_PFX_AD32 2

// ==========================================================================
// Reset values
`define RST_PRIMARY 32'h0000_0000
`define RST_FEATURE 32'h0000_0000
`define RST_EXT 32'h0000_0000
`define RST_BASE 32'h0000_0000

`endif

/* File: logic/mode_ctl_pkg.sv */
// Types shared by the mode control block.
package mode_ctl_pkg;
  typedef enum logic [2:0] {
    mode_real,
    mode_protected,
    mode_legacy_paged,
    mode_compat,
    mode_long64,
    mode_reserved
  } op_mode_t;

  typedef enum logic [1:0] {
    size_16,
    size_32,
    size_64
  } op_size_t;
endpackage

/* File: logic/mode_decode.sv */
// Code segment decode into execution mode and operand and address sizes.
`timescale 1ns/10ps
module mode_decode
(
  // Mode state
  input wire logic prot_on,
  input wire logic paging_on,
  input wire logic ext_active,
  // Code segment bits
  input wire logic seg_long,
  input wire logic seg_default,
  // Prefix overrides
  input wire logic pfx_op64,
  input wire logic pfx_op16,
  input wire logic pfx_ad32,
  // Decoded outputs
  output mode_ctl_pkg::op_mode_t mode,
  output mode_ctl_pkg::op_size_t op_size,
  output mode_ctl_pkg::op_size_t addr_size
);
  // ==========================================================================
  // Decode
  wire long64 = ext_active && seg_long && !seg_default;
  wire reserved_enc = ext_active && seg_long && seg_default;
  wire def32 = seg_default;

  // Mode select; without the extended mode the code segment long bit is ignored.
  always_comb
  begin
    op_size = def32 ? mode_ctl_pkg::size_32 : mode_ctl_pkg::size_16;
    addr_size = def32 ? mode_ctl_pkg::size_32 : mode_ctl_pkg::size_16;
    if (!prot_on)
    begin
      mode = mode_ctl_pkg::mode_real;
      op_size = mode_ctl_pkg::size_16;
      addr_size = mode_ctl_pkg::size_16;
    end
    else if (reserved_enc)
      mode = mode_ctl_pkg::mode_reserved;
    else if (long64)
    begin
      mode = mode_ctl_pkg::mode_long64;
      op_size = mode_ctl_pkg::size_32;
      addr_size = mode_ctl_pkg::size_64;
      if (pfx_op64)
        op_size = mode_ctl_pkg::size_64;
      else if (pfx_op16)
        op_size = mode_ctl_pkg::size_16;
      if (pfx_ad32)
        addr_size = mode_ctl_pkg::size_32;
    end
    else if (ext_active)
      mode = mode_ctl_pkg::mode_compat;
    else if (paging_on)
      mode = mode_ctl_pkg::mode_legacy_paged;
    else
      mode = mode_ctl_pkg::mode_protected;
  end
endmodule

/* File: logic/mode_ctl.sv */
// Operating mode control registers with extended mode consistency checks over APB.
`timescale 1ns/10ps
`include "mode_ctl_cfg.svh"
module mode_ctl
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode status
  output logic gp_fault,
  output logic ext_mode_active,
  output mode_ctl_pkg::op_mode_t cur_mode,
  output mode_ctl_pkg::op_size_t cur_op_size,
  output mode_ctl_pkg::op_size_t cur_addr_size,
  output logic [1:0] current_privilege_level,
  output logic translate_extended,
  output logic extra_regs_valid
);
  // ==========================================================================
  // State
  logic [31:0] primary_control_reg;
  logic [31:0] feature_control_reg;
  logic [31:0] ext_feature_reg;
  logic [63:0] page_table_base_reg;
  logic [2:0] seg_reg;
  logic [2:0] prefix_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic gp_reg;
  logic gp_sticky_reg;
  logic [1:0] cpl_reg;
  logic extra_valid_reg;
  logic left_ext_reg;
  mode_ctl_pkg::op_mode_t mode_reg;
  mode_ctl_pkg::op_size_t op_size_reg;
  mode_ctl_pkg::op_size_t addr_size_reg;
  mode_ctl_pkg::op_mode_t mode_next;
  mode_ctl_pkg::op_size_t op_size_next;
  mode_ctl_pkg::op_size_t addr_size_next;

  // ==========================================================================
  // APB decode; the slave answers one cycle into the access phase, so every
  // transfer has exactly one wait state.
  wire access = psel && penable && !pready_reg;
  wire wr = access && pwrite;
  wire hit_primary = paddr == `ADDR_PRIMARY;
  wire hit_feature = paddr == `ADDR_FEATURE;
  wire hit_ext = paddr == `ADDR_EXT;
  wire hit_base_lo = paddr == `ADDR_BASE_LO;
  wire hit_base_hi = paddr == `ADDR_BASE_HI;
  wire hit_seg = paddr == `ADDR_SEG;
  wire hit_status = paddr == `ADDR_STATUS;
  wire hit_prefix = paddr == `ADDR_PREFIX;
  wire mapped = hit_primary || hit_feature || hit_ext || hit_base_lo || hit_base_hi
    || hit_seg || hit_status || hit_prefix;

  // ==========================================================================
  // Current and proposed mode-control bits
  wire pe_now = primary_control_reg[`BIT_PE];
  wire pg_now = primary_control_reg[`BIT_PG];
  wire pae_now = feature_control_reg[`BIT_PAE];
  wire lme_now = ext_feature_reg[`BIT_LME];
  wire lma_now = ext_feature_reg[`BIT_LMA];
  wire pe_new = hit_primary ? pwdata[`BIT_PE] : pe_now;
  wire pg_new = hit_primary ? pwdata[`BIT_PG] : pg_now;
  wire pae_new = hit_feature ? pwdata[`BIT_PAE] : pae_now;
  wire lme_new = hit_ext ? pwdata[`BIT_LME] : lme_now;
  wire pg_rise = !pg_now && pg_new;
  wire pg_fall = pg_now && !pg_new;
  wire activate = pg_rise && lme_now;

  // ==========================================================================
  // Consistency checks
  // checks on enable-bit writes
  wire touches = wr && (hit_primary || hit_feature || hit_ext);
  wire chk_lme = hit_ext && (lme_new != lme_now) && pg_now;
  wire chk_pae_first = pg_rise && lme_now && !pae_now;
  wire chk_pae_clear = lma_now && pae_now && !pae_new;
  wire chk_seg_long = activate && seg_reg[`BIT_SEG_L];
  wire chk_task16 = activate && seg_reg[`BIT_TASK16];
  wire chk_pg_pe = pg_new && !pe_new && hit_primary;
  wire check_fail = touches && (chk_lme || chk_pae_first || chk_pae_clear || chk_seg_long
    || chk_task16 || chk_pg_pe);
  wire commit = wr && !check_fail;

  // ==========================================================================
  // Read multiplexer; unused bits of the segment, prefix and status words read as zero.
  wire [31:0] status_word = {23'h000000, extra_valid_reg, gp_sticky_reg, cpl_reg,
    translate_extended, addr_size_reg, op_size_reg};
  wire [31:0] rd_mux = hit_primary ? primary_control_reg :
    hit_feature ? feature_control_reg :
    hit_ext ? ext_feature_reg :
    hit_base_lo ? page_table_base_reg[31:0] :
    hit_base_hi ? page_table_base_reg[63:32] :
    hit_seg ? {29'h00000000, seg_reg} :
    hit_status ? status_word :
    hit_prefix ? {29'h00000000, prefix_reg} : 32'h0000_0000;

  // ==========================================================================
  // Decoder for execution mode and default sizes.
  mode_decode u_decode
  (
    .prot_on(pe_now),
    .paging_on(pg_now),
    .ext_active(lma_now),
    .seg_long(seg_reg[`BIT_SEG_L]),
    .seg_default(seg_reg[`BIT_SEG_D]),
    .pfx_op64(prefix_reg[`BIT_PFX_OP64]),
    .pfx_op16(prefix_reg[`BIT_PFX_OP16]),
    .pfx_ad32(prefix_reg[`BIT_PFX_AD32]),
    .mode(mode_next),
    .op_size(op_size_next),
    .addr_size(addr_size_next)
  );

  // ==========================================================================
  // Primary control register.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      primary_control_reg <= `RST_PRIMARY;
    else if (commit && hit_primary)
      primary_control_reg <= pwdata;
  end

  // Feature control register.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      feature_control_reg <= `RST_FEATURE;
    else if (commit && hit_feature)
      feature_control_reg <= pwdata;
  end

  // Extended feature register; the active bit is hardware owned, so a
  // software write cannot forge it.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ext_feature_reg <= `RST_EXT;
    else if (commit && hit_ext)
      ext_feature_reg <= {pwdata[31:`BIT_LMA + 1], lma_now, pwdata[`BIT_LMA - 1:0]};
    else if (commit && hit_primary && activate)
      ext_feature_reg[`BIT_LMA] <= 1'b1;
    else if (commit && hit_primary && pg_fall && lma_now)
      ext_feature_reg[`BIT_LMA] <= 1'b0;
  end

  // Page table base; the upper half is writable only once the mode is active.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      page_table_base_reg <= {`RST_BASE, `RST_BASE};
    else if (wr && hit_base_lo)
      page_table_base_reg[31:0] <= pwdata;
    else if (wr && hit_base_hi && lma_now)
      page_table_base_reg[63:32] <= pwdata;
  end

  // Code segment and prefix state supplied by the execution side.
  // descriptor state untouched by activation
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      seg_reg <= 3'h0;
      prefix_reg <= 3'h0;
    end
    else
    begin
      if (wr && hit_seg)
        seg_reg <= pwdata[2:0];
      if (wr && hit_prefix)
        prefix_reg <= pwdata[2:0];
    end
  end

  // ==========================================================================
  // Privilege level: entering protected mode starts at level zero.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cpl_reg <= 2'h0;
    else if (commit && hit_primary && pwdata[`BIT_PE] && !pe_now)
      cpl_reg <= 2'h0;
  end

  // Extra register validity: kept through compatibility mode, lost once
  // the core drops to legacy or real mode.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      extra_valid_reg <= 1'b0;
      left_ext_reg <= 1'b0;
    end
    else if (mode_reg == mode_ctl_pkg::mode_long64)
    begin
      extra_valid_reg <= !left_ext_reg || extra_valid_reg;
      left_ext_reg <= 1'b0;
    end
    else if (!lma_now)
    begin
      extra_valid_reg <= 1'b0;
      left_ext_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Registered outputs and fault pulse; a new fault outranks the sticky clear.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      gp_reg <= 1'b0;
      gp_sticky_reg <= 1'b0;
      mode_reg <= mode_ctl_pkg::mode_real;
      op_size_reg <= mode_ctl_pkg::size_16;
      addr_size_reg <= mode_ctl_pkg::size_16;
    end
    else
    begin
      gp_reg <= check_fail;
      if (check_fail)
        gp_sticky_reg <= 1'b1;
      else if (wr && hit_status)
        gp_sticky_reg <= 1'b0;
      mode_reg <= mode_next;
      op_size_reg <= op_size_next;
      addr_size_reg <= addr_size_next;
    end
  end

  // APB answer registers.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= access;
      pslverr_reg <= access && (!mapped || check_fail);
      prdata_reg <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  assign translate_extended = lma_now;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign gp_fault = gp_reg;
  assign ext_mode_active = ext_feature_reg[`BIT_LMA];
  assign cur_mode = mode_reg;
  assign cur_op_size = op_size_reg;
  assign cur_addr_size = addr_size_reg;
  assign current_privilege_level = cpl_reg;
  assign extra_regs_valid = extra_valid_reg;
endmodule

/* File: verification/mode_ctl_properties.sv */
// Port checker for the mode control block.
`timescale 1ns/10ps
module mode_ctl_properties
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Mode status
  input wire logic gp_fault,
  input wire logic ext_mode_active,
  input mode_ctl_pkg::op_mode_t cur_mode,
  input mode_ctl_pkg::op_size_t cur_op_size,
  input mode_ctl_pkg::op_size_t cur_addr_size,
  input wire logic [1:0] current_privilege_level,
  input wire logic translate_extended
);
  // ==========================================================================
  // Properties
  // One clock domain, so reset disables every check from here.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_RESET_STATE: assert property ($fell(rst) |->
    !ext_mode_active && !gp_fault && !pready)
    else $error("state not cleared by reset");
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  AST_READY_CAUSE: assert property (pready |->
    $past(psel) && $past(penable) && !$past(pready))
    else $error("ready without a pending access");
  // A fault is reported only as the answer to a refused write.
  AST_FAULT_ANSWER: assert property (gp_fault |-> pready && pslverr && pwrite)
    else $error("fault outside a refused write");
  AST_FAULT_KEEPS: assert property (gp_fault |->
    $stable(ext_mode_active) ##1 $stable(ext_mode_active))
    else $error("refused write changed the active bit");
  AST_ACTIVE_BY_WRITE: assert property ($changed(ext_mode_active) |->
    pready || $past(pready))
    else $error("active bit moved without a write");
  AST_EXT_MODES: assert property (cur_mode inside {mode_ctl_pkg::mode_compat,
    mode_ctl_pkg::mode_long64} |-> $past(ext_mode_active))
    else $error("extended mode decoded while inactive");
  AST_COMPAT_SIZES: assert property (cur_mode == mode_ctl_pkg::mode_compat |->
    cur_op_size == cur_addr_size && cur_op_size != mode_ctl_pkg::size_64)
    else $error("compatibility sizes differ");
  // The decoded mode lags the active bit by one register stage.
  AST_XLAT: assert property (translate_extended |=>
    cur_mode inside {mode_ctl_pkg::mode_compat, mode_ctl_pkg::mode_long64,
    mode_ctl_pkg::mode_reserved})
    else $error("extended translation outside the extended modes");
  AST_PRIV: assert property (current_privilege_level == 2'h0 &&
    (pready || prdata == 32'h00000000))
    else $error("privilege not zero or stray read data");
endmodule

// Attach to every instance of the block.
bind mode_ctl mode_ctl_properties i_mode_ctl_properties (.core_clk, .rst, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .gp_fault, .ext_mode_active, .cur_mode, .cur_op_size,
  .cur_addr_size, .current_privilege_level, .translate_extended);

/* File: verification/mode_ctl_bench.sv */
// Self-checking bench of the mode control block over APB.
`timescale 1ns/10ps
`include "mode_ctl_cfg.svh"
module mode_ctl_bench;
  // ==========================================================================
  // Design signals and bench state
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic pready, pslverr, gp_fault, ext_mode_active, translate_extended, extra_regs_valid, re, rf;
  logic [1:0] current_privilege_level;
  mode_ctl_pkg::op_mode_t cur_mode;
  mode_ctl_pkg::op_size_t cur_op_size, cur_addr_size;
  int err_total = 0;
  int num_checks = 0;
  localparam logic [31:0] prot_en = 32'h1 << `BIT_PE;
  localparam logic [31:0] page_en = 32'h1 << `BIT_PG;
  localparam logic [31:0] both_en = prot_en | page_en;
  localparam logic [31:0] addr_ext = 32'h1 << `BIT_PAE;
  localparam logic [31:0] ext_en = 32'h1 << `BIT_LME;
  localparam logic [31:0] ext_act = 32'h1 << `BIT_LMA;
  localparam logic [31:0] seg_long = 32'h1 << `BIT_SEG_L;
  localparam logic [31:0] seg_dflt = 32'h1 << `BIT_SEG_D;

  // Free running 250 MHz clock.
  always #2 core_clk = ~core_clk;

  mode_ctl i_mode_ctl (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gp_fault, .ext_mode_active, .cur_mode, .cur_op_size, .cur_addr_size,
    .current_privilege_level, .translate_extended, .extra_regs_valid);

  // Compares with case equality so an unknown never matches.
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      $display("ERROR pready expected 1 seen %b", pready);
      err_total++;
      wrap_up();
    end
    else
    begin
      rq = prdata;
      re = pslverr;
      rf = gp_fault;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  // A refused write must show both the bus error and the fault.
  task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(a, 1'b1, d);
    chk("slverr", 32'(re), 32'(e));
    chk("fault", 32'(rf), 32'(e));
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk($sformatf("read %h", a), rq, exp);
  endtask

  // Decoded mode is registered, so give it two edges to settle.
  task mchk(input logic [2:0] m, input logic [1:0] o, input logic [1:0] s, input bit sz);
    repeat (2) @(posedge core_clk);
    chk("mode", 32'(cur_mode), 32'(m));
    if (sz)
    begin
      chk("op size", 32'(cur_op_size), 32'(o));
      chk("addr size", 32'(cur_addr_size), 32'(s));
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("active", 32'(ext_mode_active), 32'h0);
    mchk(mode_ctl_pkg::mode_real, mode_ctl_pkg::size_16, mode_ctl_pkg::size_16, 1);
    rd(`ADDR_EXT, `RST_EXT);
    rd(`ADDR_PRIMARY, `RST_PRIMARY);
    apb(12'h020, 1'b0, 32'h0);
    chk("unmapped", 32'(re), 32'h1);
    wr(`ADDR_PRIMARY, page_en, 1'b1);
    wr(`ADDR_PRIMARY, both_en, 1'b0);
    chk("privilege", 32'(current_privilege_level), 32'h0);
    rd(`ADDR_PRIMARY, both_en);
    wr(`ADDR_EXT, ext_en, 1'b1);
    $display("test protected entry done");
    wr(`ADDR_PRIMARY, prot_en, 1'b0);
    wr(`ADDR_EXT, ext_en, 1'b0);
    wr(`ADDR_PRIMARY, both_en, 1'b1);
    rd(`ADDR_PRIMARY, prot_en);
    wr(`ADDR_FEATURE, addr_ext, 1'b0);
    wr(`ADDR_BASE_LO, 32'h1234_5000, 1'b0);
    apb(`ADDR_BASE_HI, 1'b1, 32'h0000_00a5);
    rd(`ADDR_BASE_HI, `RST_BASE);
    rd(`ADDR_BASE_LO, 32'h1234_5000);
    wr(`ADDR_SEG, seg_long, 1'b0);
    wr(`ADDR_PRIMARY, both_en, 1'b1);
    wr(`ADDR_SEG, 32'h1 << `BIT_TASK16, 1'b0);
    wr(`ADDR_PRIMARY, both_en, 1'b1);
    wr(`ADDR_SEG, seg_dflt, 1'b0);
    wr(`ADDR_PRIMARY, both_en, 1'b0);
    rd(`ADDR_EXT, ext_en | ext_act);
    rd(`ADDR_SEG, seg_dflt);
    chk("translate", 32'(translate_extended), 32'h1);
    mchk(mode_ctl_pkg::mode_compat, mode_ctl_pkg::size_32, mode_ctl_pkg::size_32, 1);
    rd(`ADDR_STATUS, 32'h0000_0095);
    $display("test extended entry done");
    wr(`ADDR_FEATURE, 32'h0, 1'b1);
    wr(`ADDR_EXT, 32'h0, 1'b1);
    rd(`ADDR_EXT, ext_en | ext_act);
    apb(`ADDR_BASE_HI, 1'b1, 32'h0000_00a5);
    rd(`ADDR_BASE_HI, 32'h0000_00a5);
    wr(`ADDR_SEG, 32'h0, 1'b0);
    mchk(mode_ctl_pkg::mode_compat, mode_ctl_pkg::size_16, mode_ctl_pkg::size_16, 1);
    wr(`ADDR_SEG, seg_long, 1'b0);
    mchk(mode_ctl_pkg::mode_long64, mode_ctl_pkg::size_32, mode_ctl_pkg::size_64, 1);
    wr(`ADDR_PREFIX, 32'h1 << `BIT_PFX_OP64, 1'b0);
    mchk(mode_ctl_pkg::mode_long64, mode_ctl_pkg::size_64, mode_ctl_pkg::size_64, 1);
    wr(`ADDR_PREFIX, 32'h1 << `BIT_PFX_OP16, 1'b0);
    mchk(mode_ctl_pkg::mode_long64, mode_ctl_pkg::size_16, mode_ctl_pkg::size_64, 1);
    wr(`ADDR_PREFIX, 32'h1 << `BIT_PFX_AD32, 1'b0);
    mchk(mode_ctl_pkg::mode_long64, mode_ctl_pkg::size_32, mode_ctl_pkg::size_32, 1);
    wr(`ADDR_PREFIX, 32'h0, 1'b0);
    wr(`ADDR_SEG, seg_long | seg_dflt, 1'b0);
    mchk(mode_ctl_pkg::mode_reserved, 2'h0, 2'h0, 0);
    $display("test extended modes done");
    wr(`ADDR_SEG, seg_dflt, 1'b0);
    wr(`ADDR_PRIMARY, prot_en, 1'b0);
    chk("active", 32'(ext_mode_active), 32'h0);
    wr(`ADDR_BASE_LO, 32'h0000_8000, 1'b0);
    wr(`ADDR_EXT, 32'h0, 1'b0);
    wr(`ADDR_PRIMARY, both_en, 1'b0);
    mchk(mode_ctl_pkg::mode_legacy_paged, 2'h0, 2'h0, 0);
    chk("extra valid", 32'(extra_regs_valid), 32'h0);
    $display("test extended exit done");
    wr(`ADDR_PRIMARY, prot_en, 1'b0);
    mchk(mode_ctl_pkg::mode_protected, mode_ctl_pkg::size_32, mode_ctl_pkg::size_32, 1);
    wr(`ADDR_EXT, ext_en, 1'b0);
    wr(`ADDR_PRIMARY, both_en, 1'b0);
    chk("active", 32'(ext_mode_active), 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("active", 32'(ext_mode_active), 32'h0);
    mchk(mode_ctl_pkg::mode_real, mode_ctl_pkg::size_16, mode_ctl_pkg::size_16, 1);
    rd(`ADDR_EXT, `RST_EXT);
    rd(`ADDR_PRIMARY, `RST_PRIMARY);
    $display("test reset while active done");
    wrap_up();
  end
endmodule
